// File: hdl/ces_defs.svh
/*
 * Constants of the exception sequencer: vector numbers, reset vector
 * addresses, status word field positions and register offsets.
 * Assumes inclusion by bare name from every design file that needs it.
 */
// Notes on behaviour
// - Four source kinds, serviced by priority
// - Reset beats every other pending source
// - Init pin rising, nmi high: power-on
// - Init pin rising, nmi low: manual reset
// - Errors/interrupts at decode, start after execution
// - Nmi, break, external level, five module sources
// - External level from four encoded pins
// - Pins 1110 is level 1, 0000 level 15
// - Trap starts on execution, not decode
// - Undefined code outside slot: general illegal
// - Undefined or pc-writing in slot: slot illegal
// - Ten delayed branches own a delay slot
// - Delayed, conditional branches and trap write pc
// - Power-on fetches pc at 0, sp at 4
// - Manual reset fetches pc at 8, sp at c
// - After reset fetch: base zero, mask 1111
// - After reset, run from fetched pc
// - Push status word and pc below stack register
// - Interrupt writes its level into mask
// - Errors and instructions leave mask unchanged
// - Fetch handler address, resume there
// - Vector address is base plus four times number
`ifndef CES_DEFS_SVH
`define CES_DEFS_SVH
`define CES_POR_PC_ADDR   32'h0000_0000
`define CES_POR_SP_ADDR   32'h0000_0004
`define CES_MAN_PC_ADDR   32'h0000_0008
`define CES_MAN_SP_ADDR   32'h0000_000c
`define CES_BASE_RESET    32'h0000_0000
`define CES_MASK_RESET    4'hf
`define CES_MASK_LSB      4
`define CES_MASK_MSB      7
`define CES_PUSH_ST_OFS   32'h0000_0004
`define CES_PUSH_PC_OFS   32'h0000_0008
`define CES_VEC_GILL      8'h04
`define CES_VEC_SILL      8'h06
`define CES_VEC_CPU_AE    8'h09
`define CES_VEC_DMA_AE    8'h0a
`define CES_VEC_NMI       8'h0b
`define CES_VEC_UBRK      8'h0c
`define CES_VEC_IRL_BASE  8'h40
`define CES_LVL_NMI       4'hf
`define CES_LVL_UBRK      4'hf
`define CES_LVL_NONE      4'h0
`define CES_NUM_MOD       5
`define CES_NUM_SRC       11
`define CES_REG_BASE      8'h00
`define CES_REG_MASK      8'h04
`define CES_REG_MOD_LVL   8'h08
`define CES_REG_MOD_VEC   8'h0c
`define CES_REG_INFO      8'h10
`endif

// File: hdl/ces_pkg.sv
/*
 * Types of the exception sequencer: sequence states, source positions.
 * Assumes the constants header is included where numbers are needed.
 */
package ces_pkg;
	typedef logic [3:0] ces_level_t;
	typedef logic [7:0] ces_vec_t;
	// One-hot sequence states
	typedef enum logic [6:0] {
		S_IDLE    = 7'h01,
		S_WAIT    = 7'h02,
		S_RST_PC  = 7'h04,
		S_RST_SP  = 7'h08,
		S_PUSH_ST = 7'h10,
		S_PUSH_PC = 7'h20,
		S_VEC     = 7'h40
	} ces_state_t;
	// Bit position in the request vector; lower is more urgent
	typedef enum logic [3:0] {
		SRC_POR  = 4'h0,
		SRC_MAN  = 4'h1,
		SRC_CAE  = 4'h2,
		SRC_DAE  = 4'h3,
		SRC_NMI  = 4'h4,
		SRC_UBRK = 4'h5,
		SRC_IRL  = 4'h6,
		SRC_MOD  = 4'h7,
		SRC_TRAP = 4'h8,
		SRC_GILL = 4'h9,
		SRC_SILL = 4'ha
	} ces_src_t;
endpackage

// File: hdl/ces_prio_pick.sv
/*
 * Fixed-priority picker: the lowest set request bit wins.
 * Assumes requests are already qualified by the caller.
 */
`timescale 1ns/1ns
module ces_prio_pick #(
	parameter int N = 11
) (
	input  wire logic [N-1:0] req,
	output logic      [N-1:0] grant,
	output logic              any
);
	// Two's complement isolates the lowest set bit
	assign grant = req & (~req + {{(N-1){1'b0}}, 1'b1});
	assign any   = |req;
endmodule

// File: hdl/ces_top.sv
/*
 * Exception sequencer: ranks reset, address error, interrupt and
 * instruction sources, runs reset vector fetch or the save/vector
 * sequence over a simple memory port, and exposes base and mask over APB.
 * Assumes decoder flags are valid with decode_valid, memory answers with a
 * one-cycle mem_ack, and all inputs are synchronous to pclk.
 */
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ns
`include "ces_defs.svh"
module ces_top (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               chip_init_pin,
	input  wire logic               nmi_pin,
	input  wire logic               cpu_addr_err,
	input  wire logic               dma_addr_err,
	input  wire logic               user_break,
	input  wire ces_pkg::ces_level_t ext_level_pins,
	input  wire logic [4:0]         mod_req,
	input  wire logic               decode_valid,
	input  wire logic               dec_undef,
	input  wire logic               dec_dly_branch,
	input  wire logic               dec_pc_modify,
	input  wire logic               trap_exec,
	input  wire ces_pkg::ces_vec_t  trap_vector,
	input  wire logic               exec_idle,
	input  wire logic [31:0]        stack_index_gpr,
	input  wire logic [31:0]        program_counter,
	input  wire logic [31:0]        status_word,
	output logic                    exc_busy,
	output logic                    pc_load,
	output logic      [31:0]        new_pc,
	output logic                    sp_load,
	output logic      [31:0]        stack_pointer,
	output ces_pkg::ces_level_t     irq_mask_field,
	output logic      [31:0]        vector_base_reg,
	output logic                    mem_req,
	output logic                    mem_we,
	output logic      [31:0]        mem_addr,
	output logic      [31:0]        mem_wdata,
	input  wire logic               mem_ack,
	input  wire logic [31:0]        mem_rdata
);
	import ces_pkg::*;

	ces_state_t           state_q;
	logic                 init_pin_q;
	logic                 rst_start;
	logic                 slot_q;
	logic [31:0]          base_q;
	ces_level_t           mask_q;
	logic [19:0]          mod_lvl_q;
	ces_vec_t             mod_vec_q;
	ces_vec_t             vec_q;
	ces_vec_t             last_vec_q;
	ces_level_t           lvl_q;
	logic                 is_int_q;
	logic [31:0]          sp_base_q;
	logic [31:0]          pc_hold_q;
	logic [31:0]          mem_addr_q;
	logic [31:0]          mem_wdata_q;
	logic                 mem_we_q;
	logic                 pc_load_q;
	logic                 sp_load_q;
	logic [31:0]          new_pc_q;
	logic [31:0]          new_sp_q;
	logic [31:0]          prdata_q;
	logic                 pslverr_q;
	logic [`CES_NUM_SRC-1:0] req;
	logic [`CES_NUM_SRC-1:0] grant;
	logic                 any_req;
	ces_level_t           irl_lvl;
	ces_level_t           mod_best;
	logic [2:0]           mod_idx;
	logic                 gill;
	logic                 sill;
	ces_vec_t             pick_vec;
	ces_level_t           pick_lvl;
	logic                 pick_int;
	logic                 pick_wait;
	logic                 done_exc;
	logic                 done_rst;
	logic                 apb_wr;
	logic                 apb_setup;

	// Reset pin edge; the flop powers up high so no edge at release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_pin_q <= 1'b1;
		end else begin
			init_pin_q <= chip_init_pin;
		end
	end
	assign rst_start = !init_pin_q && chip_init_pin;

	// Active-low encoding: 1110 is level 1, 0000 is level 15
	assign irl_lvl = ~ext_level_pins;

	// Highest-level module request; ties go to the lower index
	always_comb begin
		mod_best = `CES_LVL_NONE;
		mod_idx  = 3'h0;
		for (int i = 0; i < `CES_NUM_MOD; i++) begin
			if (mod_req[i] && mod_lvl_q[4*i +: 4] > mod_best) begin
				mod_best = mod_lvl_q[4*i +: 4];
				mod_idx  = i[2:0];
			end
		end
	end

	// Delay slot follows any of the ten delayed branches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_q <= 1'b0;
		end else if (state_q != S_IDLE) begin
			slot_q <= 1'b0;
		end else if (decode_valid) begin
			slot_q <= dec_dly_branch;
		end
	end
	assign gill = decode_valid && dec_undef && !slot_q;
	// Any pc-writing opcode in the slot is illegal
	assign sill = decode_valid && slot_q &&
		(dec_undef || dec_pc_modify);

	// Request vector; interrupts other than nmi must beat the current mask
	always_comb begin
		req = '0;
		req[SRC_POR]  = rst_start && nmi_pin;
		req[SRC_MAN]  = rst_start && !nmi_pin;
		req[SRC_CAE]  = decode_valid && cpu_addr_err;
		req[SRC_DAE]  = decode_valid && dma_addr_err;
		req[SRC_NMI]  = decode_valid && nmi_pin && init_pin_q;
		req[SRC_UBRK] = decode_valid && user_break &&
			(`CES_LVL_UBRK > mask_q);
		req[SRC_IRL]  = decode_valid && (irl_lvl > mask_q);
		req[SRC_MOD]  = decode_valid && (mod_best > mask_q);
		req[SRC_TRAP] = trap_exec;
		req[SRC_GILL] = gill;
		req[SRC_SILL] = sill;
	end

	// Fixed ranking of all eleven sources
	ces_prio_pick #(
		.N (`CES_NUM_SRC)
	) u_pick (
		.req   (req),
		.grant (grant),
		.any   (any_req)
	);

	// Vector, level and start timing of the winner
	always_comb begin
		pick_vec  = `CES_VEC_GILL;
		pick_lvl  = mask_q;
		pick_int  = 1'b0;
		pick_wait = 1'b1;
		if (grant[SRC_CAE]) begin
			pick_vec = `CES_VEC_CPU_AE;
		end else if (grant[SRC_DAE]) begin
			pick_vec = `CES_VEC_DMA_AE;
		end else if (grant[SRC_NMI]) begin
			pick_vec = `CES_VEC_NMI;
			pick_lvl = `CES_LVL_NMI;
			pick_int = 1'b1;
		end else if (grant[SRC_UBRK]) begin
			pick_vec = `CES_VEC_UBRK;
			pick_lvl = `CES_LVL_UBRK;
			pick_int = 1'b1;
		end else if (grant[SRC_IRL]) begin
			pick_vec = `CES_VEC_IRL_BASE + {5'h00, irl_lvl[3:1]};
			pick_lvl = irl_lvl;
			pick_int = 1'b1;
		end else if (grant[SRC_MOD]) begin
			pick_vec = mod_vec_q + {5'h00, mod_idx};
			pick_lvl = mod_best;
			pick_int = 1'b1;
		end else if (grant[SRC_TRAP]) begin
			pick_vec  = trap_vector;
			pick_wait = 1'b0;
		end else if (grant[SRC_SILL]) begin
			pick_vec  = `CES_VEC_SILL;
			pick_wait = 1'b0;
		end else begin
			pick_wait = 1'b0;
		end
	end

	assign done_exc = (state_q == S_VEC) && mem_ack && !rst_start;
	assign done_rst = (state_q == S_RST_SP) && mem_ack && !rst_start;

	// Sequencer and memory request; a reset edge aborts anything
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q     <= S_IDLE;
			mem_addr_q  <= 32'h0000_0000;
			mem_wdata_q <= 32'h0000_0000;
			mem_we_q    <= 1'b0;
			vec_q       <= 8'h00;
			lvl_q       <= 4'h0;
			is_int_q    <= 1'b0;
			sp_base_q   <= 32'h0000_0000;
			pc_hold_q   <= 32'h0000_0000;
		end else if (rst_start) begin
			state_q    <= S_RST_PC;
			mem_we_q   <= 1'b0;
			mem_addr_q <= nmi_pin ? `CES_POR_PC_ADDR
				: `CES_MAN_PC_ADDR;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (any_req) begin
						vec_q     <= pick_vec;
						lvl_q     <= pick_lvl;
						is_int_q  <= pick_int;
						sp_base_q <= stack_index_gpr;
						state_q   <= pick_wait ? S_WAIT : S_PUSH_ST;
						mem_we_q  <= 1'b1;
						mem_addr_q <= stack_index_gpr - `CES_PUSH_ST_OFS;
						mem_wdata_q <= status_word;
					end
				end
				S_WAIT: begin
					// Hold until the running instruction retires
					if (exec_idle) begin
						state_q <= S_PUSH_ST;
					end
				end
				S_RST_PC: begin
					if (mem_ack) begin
						pc_hold_q  <= mem_rdata;
						mem_addr_q <= mem_addr_q + `CES_POR_SP_ADDR;
						state_q    <= S_RST_SP;
					end
				end
				S_RST_SP: begin
					if (mem_ack) begin
						state_q <= S_IDLE;
					end
				end
				S_PUSH_ST: begin
					if (mem_ack) begin
						mem_addr_q  <= sp_base_q - `CES_PUSH_PC_OFS;
						mem_wdata_q <= program_counter;
						state_q     <= S_PUSH_PC;
					end
				end
				S_PUSH_PC: begin
					if (mem_ack) begin
						mem_we_q   <= 1'b0;
						mem_addr_q <= base_q + {22'h0, vec_q, 2'b00};
						state_q    <= S_VEC;
					end
				end
				S_VEC: begin
					if (mem_ack) begin
						state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// Pc and sp loads toward the pipeline, one-cycle pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_load_q <= 1'b0;
			sp_load_q <= 1'b0;
			new_pc_q  <= 32'h0000_0000;
			new_sp_q  <= 32'h0000_0000;
		end else begin
			pc_load_q <= done_rst || done_exc;
			sp_load_q <= done_rst || done_exc;
			if (done_rst) begin
				new_pc_q <= pc_hold_q;
				new_sp_q <= mem_rdata;
			end else if (done_exc) begin
				new_pc_q <= mem_rdata;
				new_sp_q <= sp_base_q - `CES_PUSH_PC_OFS;
			end
		end
	end

	// Vector base; hardware update wins over a same-cycle write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_q <= `CES_BASE_RESET;
		end else if (done_rst) begin
			base_q <= `CES_BASE_RESET;
		end else if (apb_wr && paddr == `CES_REG_BASE) begin
			base_q <= pwdata;
		end
	end

	// Interrupt mask; only interrupts, resets and APB writes move it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= `CES_MASK_RESET;
		end else if (done_rst) begin
			mask_q <= `CES_MASK_RESET;
		end else if (done_exc && is_int_q) begin
			mask_q <= lvl_q;
		end else if (apb_wr && paddr == `CES_REG_MASK) begin
			mask_q <= pwdata[3:0];
		end
	end

	// Module levels, module vector base and last vector taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_lvl_q  <= 20'h00000;
			mod_vec_q  <= 8'h00;
			last_vec_q <= 8'h00;
		end else begin
			if (apb_wr && paddr == `CES_REG_MOD_LVL) begin
				mod_lvl_q <= pwdata[19:0];
			end
			if (apb_wr && paddr == `CES_REG_MOD_VEC) begin
				mod_vec_q <= pwdata[7:0];
			end
			if (done_exc) begin
				last_vec_q <= vec_q;
			end
		end
	end

	// APB slave: data prepared in setup, zero wait states
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite && !pslverr_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (apb_setup) begin
			pslverr_q <= 1'b0;
			case (paddr)
				`CES_REG_BASE:    prdata_q <= base_q;
				`CES_REG_MASK:    prdata_q <= {28'h0, mask_q};
				`CES_REG_MOD_LVL: prdata_q <= {12'h0, mod_lvl_q};
				`CES_REG_MOD_VEC: prdata_q <= {24'h0, mod_vec_q};
				`CES_REG_INFO: begin
					prdata_q <= {17'h0, state_q, last_vec_q};
					pslverr_q <= pwrite; // Read-only
				end
				default: begin
					prdata_q  <= 32'h0000_0000;
					pslverr_q <= 1'b1;
				end
			endcase
		end
	end

	assign prdata          = prdata_q;
	assign pready          = 1'b1;
	assign pslverr         = psel && penable && pslverr_q;
	assign exc_busy        = (state_q != S_IDLE);
	assign pc_load         = pc_load_q;
	assign new_pc          = new_pc_q;
	assign sp_load         = sp_load_q;
	assign stack_pointer   = new_sp_q;
	assign irq_mask_field  = mask_q;
	assign vector_base_reg = base_q;
	assign mem_req         = (state_q != S_IDLE) && (state_q != S_WAIT);
	assign mem_we          = mem_we_q;
	assign mem_addr        = mem_addr_q;
	assign mem_wdata       = mem_wdata_q;

	// Checks on the sequencer
	rst_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		rst_start |=> state_q == S_RST_PC)
		else $error("reset edge did not start reset fetch");
	por_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
		rst_start && nmi_pin |=> mem_addr_q == `CES_POR_PC_ADDR)
		else $error("power-on pc address wrong");
	man_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == S_RST_PC && mem_addr_q == `CES_MAN_PC_ADDR && mem_ack
		&& !rst_start |=> mem_addr_q == `CES_MAN_SP_ADDR)
		else $error("manual reset sp address wrong");
	rst_init_a: assert property (@(posedge pclk) disable iff (!presetn)
		done_rst |=> base_q == `CES_BASE_RESET
		&& mask_q == `CES_MASK_RESET && pc_load)
		else $error("reset did not set base and mask");
	wait_exec_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == S_WAIT && !exec_idle && !rst_start
		|=> state_q == S_WAIT && !mem_req)
		else $error("handling started before instruction end");
	push_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == S_PUSH_ST && mem_ack && !rst_start
		|=> mem_addr == sp_base_q - `CES_PUSH_PC_OFS && mem_we)
		else $error("pc push address wrong");
	vec_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == S_PUSH_PC && mem_ack && !rst_start
		|=> mem_addr == $past(base_q) + {22'h0, $past(vec_q), 2'b00})
		else $error("vector address wrong");
	mask_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		done_exc && !is_int_q && !apb_wr |=> $stable(mask_q))
		else $error("mask changed on non-interrupt");
	mask_int_a: assert property (@(posedge pclk) disable iff (!presetn)
		done_exc && is_int_q |=> mask_q == $past(lvl_q))
		else $error("mask not set to interrupt level");
	irl_lvl_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == S_IDLE && !rst_start && grant[SRC_IRL]
		|=> lvl_q == ~$past(ext_level_pins))
		else $error("external level decoded wrong");
endmodule

// File: verif/ces_mem_model.sv
/*
 * Memory model at the sequencer's memory port: answers each request with
 * a one-cycle ack, promptly or after three wait cycles, and logs accesses.
 * Assumes mem_req is held with its address and data until the ack.
 */
`timescale 1ns/1ns
module ces_mem_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic             mem_ack,
	output logic [31:0]      mem_rdata
);
	logic [1:0]  wait_q;
	logic [64:0] log_q[$];

	// Read data is a fixed pattern of the address; outside an ack the
	// data lines keep toggling so a stale sample never passes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack   <= 1'b0;
			wait_q    <= 2'h0;
			mem_rdata <= 32'h0;
		end else if (mem_ack || !mem_req) begin
			mem_ack   <= 1'b0;
			wait_q    <= slow ? 2'h3 : 2'h0;
			mem_rdata <= ~mem_rdata;
		end else if (wait_q != 2'h0) begin
			wait_q    <= wait_q - 2'h1;
			mem_rdata <= ~mem_rdata;
		end else begin
			mem_ack   <= 1'b1;
			mem_rdata <= mem_we ? ~mem_rdata : mem_addr ^ 32'h0bad_0000;
			log_q.push_back({mem_we, mem_addr,
				mem_we ? mem_wdata : mem_addr ^ 32'h0bad_0000});
		end
	end
endmodule

// File: verif/ces_top_bench.sv
/*
 * Bench of the exception sequencer: APB accesses, reset sequences and
 * exception sequences checked against the memory model's access log.
 * Assumes ces_pkg, ces_top and ces_mem_model are compiled first.
 */
`timescale 1ns/1ns
module ces_top_bench;
	import ces_pkg::*;
	localparam logic [7:0]  A_BASE = 8'h00;
	localparam logic [7:0]  A_MASK = 8'h04;
	localparam logic [7:0]  A_LVL  = 8'h08;
	localparam logic [7:0]  A_MVEC = 8'h0c;
	localparam logic [31:0] STK    = 32'h0000_2000;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, new_pc, stack_pointer, vector_base_reg;
	logic        chip_init_pin, nmi_pin, cpu_addr_err, dma_addr_err;
	logic        user_break, decode_valid, dec_undef, dec_dly_branch;
	logic        dec_pc_modify, trap_exec, exec_idle, exc_busy, slow;
	logic        pc_load, sp_load, mem_req, mem_we, mem_ack;
	logic [4:0]  mod_req;
	ces_level_t  ext_level_pins, irq_mask_field;
	ces_vec_t    trap_vector;
	logic [31:0] stack_index_gpr, program_counter, status_word;
	logic [31:0] mem_addr, mem_wdata, mem_rdata, base_e;
	int          error_cnt, checks;

	ces_top ces_top_i (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .chip_init_pin, .nmi_pin, .cpu_addr_err,
		.dma_addr_err, .user_break, .ext_level_pins, .mod_req, .decode_valid,
		.dec_undef, .dec_dly_branch, .dec_pc_modify, .trap_exec, .trap_vector,
		.exec_idle, .stack_index_gpr, .program_counter, .status_word,
		.exc_busy, .pc_load, .new_pc, .sp_load, .stack_pointer,
		.irq_mask_field, .vector_base_reg, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_ack, .mem_rdata
	);
	ces_mem_model ces_mem_model_i (
		.pclk, .presetn, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_ack, .mem_rdata
	);

	// Free-running system clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	function automatic logic [31:0] vw(input logic [31:0] a);
		return a ^ 32'h0bad_0000;
	endfunction

	task automatic tally_and_finish();
		if (error_cnt == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic acc(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic err_e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			error_cnt++;
			tally_and_finish();
		end
		chk(pslverr, err_e);
		if (!wr)
			chk(prdata, d);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Decoded instruction with its source flags for one cycle
	task automatic decode(input logic [6:0] f);
		@(posedge pclk);
		{dec_pc_modify, dec_dly_branch, dec_undef, user_break, nmi_pin,
			dma_addr_err, cpu_addr_err} <= f;
		decode_valid <= 1'b1;
		@(posedge pclk);
		decode_valid <= 1'b0;
	endtask

	task automatic quiet(input int n);
		repeat (n) begin
			@(negedge pclk);
			chk(mem_req, 1'b0);
		end
	endtask

	// Bounded wait for the end of a sequence
	task automatic wait_load();
		int n;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (pc_load !== 1'b1 && n < 200);
		if (n >= 200) begin
			error_cnt++;
			tally_and_finish();
		end
		chk(sp_load, 1'b1);
	endtask

	task automatic run_reset(input logic nmi, input logic [31:0] a);
		@(posedge pclk);
		chip_init_pin <= 1'b0;
		@(posedge pclk);
		nmi_pin       <= nmi;
		chip_init_pin <= 1'b1;
		wait_load();
		chk(ces_mem_model_i.log_q[$-1], {1'b0, a, vw(a)});
		chk(ces_mem_model_i.log_q[$], {1'b0, a + 32'h4, vw(a + 32'h4)});
		chk({new_pc, stack_pointer}, {vw(a), vw(a + 32'h4)});
		chk({vector_base_reg, irq_mask_field}, {32'h0, 4'hf});
		base_e = 32'h0;
	endtask

	task automatic check_exc(input logic [7:0] v, input logic [3:0] mo);
		logic [31:0] va;
		va = base_e + {22'h0, v, 2'b00};
		wait_load();
		chk(ces_mem_model_i.log_q[$-2], {1'b1, STK - 32'h4, status_word});
		chk(ces_mem_model_i.log_q[$-1], {1'b1, STK - 32'h8, program_counter});
		chk(ces_mem_model_i.log_q[$], {1'b0, va, vw(va)});
		chk({new_pc, stack_pointer}, {vw(va), STK - 32'h8});
		chk(irq_mask_field, mo);
	endtask

	// Mask set, sources raised at one decode, handler entry checked
	task automatic run_exc(input logic [6:0] p, input logic [6:0] f,
		input logic [3:0] ext, input logic [4:0] mr, input logic [3:0] mi,
		input logic hold, input logic [7:0] v, input logic [3:0] mo);
		acc(1'b1, A_MASK, {28'h0, mi}, 1'b0);
		ext_level_pins <= ext;
		mod_req        <= mr;
		exec_idle      <= !hold;
		if (p != 7'h0)
			decode(p);
		decode(f);
		if (hold) begin
			quiet(4);
			chk(exc_busy, 1'b1);
			@(posedge pclk);
			exec_idle <= 1'b1;
		end
		check_exc(v, mo);
		@(posedge pclk);
		ext_level_pins <= 4'hf;
		mod_req        <= 5'h0;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, chip_init_pin,
			cpu_addr_err, dma_addr_err, user_break, mod_req, decode_valid,
			dec_undef, dec_dly_branch, dec_pc_modify, trap_exec,
			trap_vector, slow} = '0;
		{nmi_pin, exec_idle, ext_level_pins} = 6'h3f;
		stack_index_gpr = STK;
		program_counter = 32'h0000_0444;
		status_word     = 32'h0000_00f0;
		error_cnt = 0;
		checks    = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		run_reset(1'b1, 32'h0);
		acc(1'b0, A_MASK, 32'hf, 1'b0);
		acc(1'b0, 8'h20, 32'h0, 1'b1);
		acc(1'b1, 8'h10, 32'h0, 1'b1);
		acc(1'b0, 8'h10, 32'h100, 1'b0);
		acc(1'b1, A_BASE, 32'h100, 1'b0);
		acc(1'b0, A_BASE, 32'h100, 1'b0);
		base_e = 32'h100;
		acc(1'b1, A_MVEC, 32'h80, 1'b0);
		for (int i = 0; i < 5; i++) begin
			acc(1'b1, A_LVL, 32'h2 << (4 * i), 1'b0);
			run_exc(0, 0, 4'hf, 5'h1 << i, 0, 0, 8'h80 | 8'(i), 2);
		end
		acc(1'b0, A_LVL, 32'h2_0000, 1'b0);
		run_exc(0, 7'h17, 4'hf, 0, 3, 0, 9, 3);
		run_exc(0, 7'h06, 4'hf, 0, 3, 0, 10, 3);
		run_exc(0, 7'h0c, 4'h0, 0, 3, 0, 11, 4'hf);
		run_exc(0, 7'h08, 4'h0, 5'h10, 3, 0, 12, 4'hf);
		run_exc(0, 7'h10, 4'h0, 5'h10, 3, 1, 71, 4'hf);
		slow <= 1'b1;
		run_exc(0, 7'h10, 4'hf, 5'h10, 1, 0, 8'h84, 2);
		run_exc(0, 7'h10, 4'hf, 0, 1, 0, 4, 1);
		run_exc(7'h20, 7'h40, 4'hf, 0, 1, 0, 6, 1);
		run_exc(7'h20, 7'h10, 4'hf, 0, 1, 0, 6, 1);
		run_exc(0, 0, 4'he, 0, 0, 0, 64, 1);
		// Level not above the mask is ignored
		ext_level_pins <= 4'he;
		decode(0);
		quiet(5);
		// Trap starts at execution only
		acc(1'b1, A_MASK, 32'h5, 1'b0);
		ext_level_pins <= 4'hf;
		decode(0);
		quiet(3);
		trap_vector <= 8'h21;
		trap_exec   <= 1'b1;
		@(posedge pclk);
		trap_exec <= 1'b0;
		check_exc(8'h21, 4'h5);
		// Reset arriving in mid-sequence takes over
		ext_level_pins <= 4'h0;
		decode(0);
		repeat (4) @(posedge pclk);
		run_reset(1'b0, 32'h8);
		ext_level_pins <= 4'hf;
		tally_and_finish();
	end
endmodule
